// ---- rtl/emsp_pins.sv ----
// external memory bank selects and sdram control pins
`default_nettype none
`include "emsp_map.svh"
module emsp_pins #(
  parameter int ADDR_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire emsp_pkg::emsp_req_t req,
  output logic req_done,
  input wire logic refresh_req,
  input wire logic configured,
  input wire logic clock_gate_en,
  input wire logic clk_b_off,
  input wire logic clk_all_off,
  input wire logic boot_flash,
  input wire logic [1:0] flag2_mode,
  input wire logic [1:0] flag3_mode,
  input wire logic flag2_out,
  input wire logic flag3_out,
  input wire logic timer_expired,
  input wire logic ack,
  input wire logic flag2_in,
  input wire logic flag3_in,
  output logic irq2_req,
  output logic [ADDR_W-1:0] addr_out,
  output logic sdram_row_bit_ten,
  output logic [1:0] bank_select_n,
  output emsp_pkg::emsp_sdcmd_t sdram_cmd,
  output logic sdram_clock_gate,
  output logic sdram_clock_out_a,
  output logic sdram_clock_out_a_oe,
  output logic sdram_clock_out_b,
  output logic sdram_clock_out_b_oe,
  output logic flag2_o,
  output logic flag2_oe,
  output logic flag2_pullup,
  output logic flag3_o,
  output logic flag3_oe,
  output logic flag3_pullup
);
  // ****************************************
  // access sequencing
  // ****************************************
  emsp_pkg::emsp_state_t state_ff;
  emsp_pkg::emsp_state_t nxt_state;
  emsp_pkg::emsp_req_t cur_ff;
  logic [3:0] bank_ff;
  logic refresh_ff;
  logic clk_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      emsp_pkg::EMSP_IDLE: if (req_valid && configured) begin
        nxt_state = emsp_pkg::EMSP_BUSY;
      end
      emsp_pkg::EMSP_BUSY: if (ack) begin
        nxt_state = emsp_pkg::EMSP_DONE;
      end
      emsp_pkg::EMSP_DONE: nxt_state = emsp_pkg::EMSP_IDLE;
      default: nxt_state = emsp_pkg::EMSP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= emsp_pkg::EMSP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else if (state_ff == emsp_pkg::EMSP_IDLE && req_valid) begin
      cur_ff <= req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_done <= 1'b0;
    end else begin
      req_done <= (state_ff == emsp_pkg::EMSP_BUSY) && ack;
    end
  end

  // ****************************************
  // address and bank selects
  // ****************************************
  logic start;
  assign start = (state_ff == emsp_pkg::EMSP_IDLE) && req_valid && configured;

  // selects load with the address so both change on the same edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_out <= '0;
      bank_ff <= `EMSP_BANK_RST;
    end else if (start) begin
      addr_out <= req.addr;
      // condition outcome is ignored for the select
      bank_ff <= ~(4'h1 << req.bank);
    end else if (nxt_state == emsp_pkg::EMSP_IDLE) begin
      bank_ff <= `EMSP_BANK_RST;
    end
  end
  assign bank_select_n = bank_ff[1:0];

  // ****************************************
  // sdram pins
  // ****************************************
  // refresh uses only the row bit and strobes, so it overlaps async access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refresh_ff <= 1'b0;
      sdram_cmd <= '1;
      sdram_row_bit_ten <= 1'b0;
    end else begin
      refresh_ff <= refresh_req && !refresh_ff && configured;
      if (refresh_req && !refresh_ff && configured) begin
        sdram_cmd <= 3'h1;
        sdram_row_bit_ten <= 1'b0;
      end else if (start && req.sdram) begin
        // a false condition keeps the write strobe high, select still drops
        sdram_cmd <= {2'h0, req.conditional && !req.cond_true};
        sdram_row_bit_ten <= req.addr[`EMSP_ROW_BIT];
      end else begin
        sdram_cmd <= '1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdram_clock_gate <= 1'b1;
    end else begin
      sdram_clock_gate <= !configured || clock_gate_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_ff <= 1'b0;
      sdram_clock_out_a <= 1'b0;
      sdram_clock_out_b <= 1'b0;
      sdram_clock_out_a_oe <= 1'b0;
      sdram_clock_out_b_oe <= 1'b0;
    end else begin
      clk_ff <= !clk_ff;
      sdram_clock_out_a <= clk_ff;
      sdram_clock_out_b <= clk_ff;
      sdram_clock_out_a_oe <= !clk_all_off;
      sdram_clock_out_b_oe <= !clk_all_off && !clk_b_off;
    end
  end

  // ****************************************
  // multiplexed flag pins
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag2_o <= 1'b1;
      flag2_oe <= 1'b0;
      flag2_pullup <= 1'b0;
      irq2_req <= 1'b0;
    end else begin
      flag2_pullup <= flag2_mode == `EMSP_FMODE_BANK;
      irq2_req <= (flag2_mode == `EMSP_FMODE_ALT) && !flag2_in;
      flag2_oe <= flag2_mode != `EMSP_FMODE_ALT;
      flag2_o <= (flag2_mode == `EMSP_FMODE_BANK) ? nxt_bank(2) : flag2_out;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag3_o <= 1'b1;
      flag3_oe <= 1'b0;
      flag3_pullup <= 1'b0;
    end else begin
      flag3_pullup <= flag3_mode == `EMSP_FMODE_BANK;
      flag3_oe <= 1'b1;
      unique case (flag3_mode)
        `EMSP_FMODE_ALT: flag3_o <= timer_expired;
        `EMSP_FMODE_BANK: flag3_o <= nxt_bank(3);
        default: flag3_o <= flag3_out;
      endcase
    end
  end

  // flag pin selects track the bank register on the same edge
  function automatic logic nxt_bank(input int idx);
    logic [3:0] v;
    v = bank_ff;
    if (start) begin
      v = ~(4'h1 << req.bank);
    end else if (nxt_state == emsp_pkg::EMSP_IDLE) begin
      v = `EMSP_BANK_RST;
    end
    return v[idx[1:0]];
  endfunction

  logic unused_in;
  assign unused_in = flag3_in ^ boot_flash ^ cur_ff.sdram;

  // ****************************************
  // checks
  // ****************************************
  sequence acc_start_s;
    start;
  endsequence

  idle_banks_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == emsp_pkg::EMSP_IDLE && !$past(start) |-> bank_ff == 4'hf)
    else $error("bank select active while idle");
  cond_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_start_s |=> bank_ff[$past(req.bank)] == 1'b0)
    else $error("addressed bank not selected");
  addr_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_start_s |=> addr_out == $past(req.addr))
    else $error("address not loaded with select");
  wait_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == emsp_pkg::EMSP_BUSY && !ack |=> !req_done)
    else $error("access done without ack");
  row_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && req.sdram && !(refresh_req && !refresh_ff && configured)
    |=> sdram_row_bit_ten == $past(req.addr[10]))
    else $error("row bit mismatch");
  clk_b_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_b_off |=> !sdram_clock_out_b_oe)
    else $error("second clock not tristated");
  clk_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_all_off |=> !sdram_clock_out_a_oe && !sdram_clock_out_b_oe)
    else $error("clocks not tristated");
  pullup_f2_a: assert property (@(posedge clk) disable iff (!rst_n)
    flag2_mode == 2'h2 |=> flag2_pullup && flag2_oe)
    else $error("flag two bank mode wrong");
  timer_f3_a: assert property (@(posedge clk) disable iff (!rst_n)
    flag3_mode == 2'h1 |=> flag3_o == $past(timer_expired))
    else $error("timer expiry not driven");
  gate_rst_a: assert property (@(posedge clk) disable iff (!rst_n)
    !configured |=> sdram_clock_gate && sdram_cmd.we_n)
    else $error("unconfigured pins not inactive");
endmodule // emsp_pins
`default_nettype wire

// ---- pkg/emsp_map.svh ----
// field positions, reset values, mode codes and timing counts of the pin block
`ifndef EMSP_MAP_SVH
`define EMSP_MAP_SVH
`define EMSP_ROW_BIT 10
`define EMSP_BANK_RST 4'hf
`define EMSP_FMODE_FLAG 2'h0
`define EMSP_FMODE_ALT 2'h1
`define EMSP_FMODE_BANK 2'h2
`define EMSP_CLK_DIV 2
`endif

// ---- pkg/emsp_pkg.sv ----
// types for the external memory select and sdram pin block
`default_nettype none
package emsp_pkg;
  typedef enum logic [2:0] {
    EMSP_IDLE = 3'h1,
    EMSP_BUSY = 3'h2,
    EMSP_DONE = 3'h4
  } emsp_state_t;

  // sdram command pins, active low
  typedef struct packed {
    logic row_n;
    logic col_n;
    logic we_n;
  } emsp_sdcmd_t;

  // one request from the core side
  typedef struct packed {
    logic [23:0] addr;
    logic sdram;
    logic [1:0] bank;
    logic conditional;
    logic cond_true;
  } emsp_req_t;
endpackage
`default_nettype wire

// ---- verif/emsp_mem_model.sv ----
// external memory model that answers with acknowledge
`default_nettype none
module emsp_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] bank_select_n,
  input wire logic [3:0] waits,
  output logic ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (!rst_n || &bank_select_n) cnt_ff <= 4'h0;
    else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
  end
  // low while selected until the wait count has run out
  // pulled high while no bank is selected
  assign ack = (&bank_select_n) ? 1'b1 : (cnt_ff >= waits);
endmodule // emsp_mem_model
`default_nettype wire

// ---- verif/tb_emsp_pins.sv ----
// self-checking bench for the bank select and sdram pin block
`default_nettype none
module tb_emsp_pins;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, req_valid, req_done, refresh_req, row_bit, ack;
  logic gate, a_oe, b_oe;
  logic clk_a, clk_b, f2_o, f2_oe, f2_pu, f3_o, f3_oe, f3_pu, irq2;
  logic [1:0] bank_select_n;
  logic [3:0] waits;
  logic [13:0] m;
  logic [23:0] addr_out;
  emsp_pkg::emsp_req_t req;
  emsp_pkg::emsp_sdcmd_t sdram_cmd;
  int mismatches, checks_done, cyc;
  emsp_pins emsp_pins_inst (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_done(req_done),
    .refresh_req(refresh_req), .configured(m[0]), .clock_gate_en(m[1]),
    .clk_b_off(m[2]), .clk_all_off(m[3]), .boot_flash(m[4]),
    .flag2_mode(m[9:8]), .flag3_mode(m[11:10]), .flag2_out(m[5]),
    .flag3_out(m[6]), .timer_expired(m[7]), .ack(ack),
    .flag2_in(m[12]), .flag3_in(m[13]), .irq2_req(irq2),
    .addr_out(addr_out),
    .sdram_row_bit_ten(row_bit), .bank_select_n(bank_select_n),
    .sdram_cmd(sdram_cmd), .sdram_clock_gate(gate),
    .sdram_clock_out_a(clk_a),
    .sdram_clock_out_a_oe(a_oe), .sdram_clock_out_b(clk_b),
    .sdram_clock_out_b_oe(b_oe), .flag2_o(f2_o), .flag2_oe(f2_oe),
    .flag2_pullup(f2_pu), .flag3_o(f3_o), .flag3_oe(f3_oe),
    .flag3_pullup(f3_pu));
  emsp_mem_model emsp_mem_model_inst (.clk(clk), .rst_n(rst_n),
    .bank_select_n(bank_select_n), .waits(waits), .ack(ack));
  // ****************
  // shared tasks
  // ****************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic access(input emsp_pkg::emsp_req_t r, input logic rf,
                        input logic [3:0] w);
    int n;
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    refresh_req <= rf;
    waits <= w;
    @(posedge clk);
    req_valid <= 1'b0;
    refresh_req <= 1'b0;
    #1;
    n = 0;
    chk(bank_select_n, 2'(~(2'b01 << r.bank)));
    chk(addr_out, r.addr);
    if (rf) chk({sdram_cmd, row_bit}, 4'h2);
    if (r.sdram) chk(row_bit, r.addr[10]);
    if (r.sdram && !rf)
      chk(sdram_cmd, {2'h0, r.conditional && !r.cond_true});
    if (m[9:8] == 2'h2) chk(f2_o, r.bank != 2'h2);
    if (m[11:10] == 2'h2) chk(f3_o, r.bank != 2'h3);
    while (req_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, 32'(w) + 1);
    @(posedge clk);
    #1;
    chk(bank_select_n, 2'h3);
    if (m[11:8] == 4'ha) chk({f2_o, f3_o}, 2'h3);
    $display("access test at %h done", r.addr);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic clock_pins;
    logic ph;
    @(posedge clk);
    m[3:1] <= 3'h2;
    repeat (2) @(posedge clk);
    #1;
    chk({gate, a_oe, b_oe}, 3'h2);
    ph = clk_a;
    chk(clk_b, ph);
    @(posedge clk);
    m[3] <= 1'b1;
    #1;
    chk({clk_a, clk_b}, {~ph, ~ph});
    repeat (2) @(posedge clk);
    #1;
    chk({a_oe, b_oe}, 2'h0);
    @(posedge clk);
    m[3:1] <= 3'h1;
    $display("clock pin test done");
  endtask
  task automatic unconfigured;
    @(posedge clk);
    m[1:0] <= 2'h0;
    req <= '{24'h000800, 1'b1, 2'h1, 1'b0, 1'b0};
    req_valid <= 1'b1;
    refresh_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({bank_select_n, sdram_cmd, gate, req_done}, 7'h7e);
    @(posedge clk);
    req_valid <= 1'b0;
    refresh_req <= 1'b0;
    m[1:0] <= 2'h3;
    $display("unconfigured test done");
  endtask
  task automatic flag_pins;
    @(posedge clk);
    m[13:5] <= 9'h025;
    repeat (2) @(posedge clk);
    #1;
    chk({f2_o, f2_oe, f2_pu, f3_o, f3_oe, f3_pu, irq2}, 7'h6c);
    @(posedge clk);
    m[13:5] <= 9'h00a;
    repeat (2) @(posedge clk);
    #1;
    chk({f2_oe, f2_pu, f3_o, f3_oe, f3_pu, irq2}, 6'h0d);
    @(posedge clk);
    m[13:5] <= 9'h050;
    repeat (2) @(posedge clk);
    #1;
    chk({f2_o, f2_oe, f2_pu, f3_o, f3_oe, f3_pu, irq2}, 7'h7e);
    access('{24'h200000, 1'b0, 2'h2, 1'b0, 1'b0}, 1'b0, 4'h0);
    access('{24'h300000, 1'b1, 2'h3, 1'b0, 1'b0}, 1'b0, 4'h0);
    $display("flag pin test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, req_valid, refresh_req, waits, m, req} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    m[1:0] <= 2'h3;
    #1;
    chk({bank_select_n, sdram_cmd, row_bit, gate}, 7'h7d);
    $display("reset test done");
    clock_pins();
    access('{24'h123456, 1'b1, 2'h0, 1'b0, 1'b0}, 1'b0, 4'h0);
    access('{24'h000400, 1'b0, 2'h0, 1'b0, 1'b0}, 1'b1, 4'h0);
    access('{24'h0003ff, 1'b0, 2'h1, 1'b1, 1'b0}, 1'b0, 4'h3);
    access('{24'h000c00, 1'b1, 2'h0, 1'b1, 1'b0}, 1'b0, 4'h2);
    unconfigured();
    flag_pins();
    wrap_up();
  end
endmodule // tb_emsp_pins
`default_nettype wire
